// file: hdl/adcop_pkg.sv
// Constants for the converter sample output port.
// Assumes one sampling clock; the analog front end delivers a raw signed-range sample.
//
// What this block does
// - With the drive control low the ten code outputs and the range flag are driven.
// - With the drive control high the code outputs and the range flag are released.
// - While the hold input is high the code outputs keep the last state they held.
// - While the hold input is low the code outputs update with each new result.
// - An in-range sample gives its straight-binary code 0 to 1023 and a range flag of 1.
// - Below range gives code 0 and above range gives 1023, with the range flag 0.
package adcop_pkg;
   localparam int unsigned      ADCOP_CODE_W   = 10;
   localparam int unsigned      ADCOP_RAW_W    = 12;
   localparam logic [9:0]       ADCOP_CODE_MIN = 10'h000;
   localparam logic [9:0]       ADCOP_CODE_MAX = 10'h3ff;
   localparam logic [11:0]      ADCOP_RAW_MIN  = 12'h000;
   localparam logic [11:0]      ADCOP_RAW_MAX  = 12'h3ff;
   localparam logic             ADCOP_DRIVE_ON = 1'h0;
   localparam logic             ADCOP_HOLD_ON  = 1'h1;
   localparam logic             ADCOP_FLAG_IN  = 1'h1;
   localparam logic             ADCOP_FLAG_OUT = 1'h0;
   localparam logic             ADCOP_OE_ON    = 1'h1;
   localparam logic             ADCOP_OE_OFF   = 1'h0;
endpackage : adcop_pkg

// file: hdl/adcop_top.sv
// Output stage of a 10-bit sampling converter: saturation, range flag, hold and drive enable.
// Assumes raw_sample is a signed value from the quantiser, synchronous to ref_clk.
// Every pin output and its enable comes straight from a register.
// Assumes the pad ring turns each enable into a three-state driver.
`timescale 1ns/1ns
`default_nettype none
module adcop_top
   import adcop_pkg::*;
#(
   parameter int unsigned RAW_W = ADCOP_RAW_W
)
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic signed [RAW_W-1:0] raw_sample,
   input  wire logic                    output_drive_n,
   input  wire logic                    low_power_hold,
   output var  logic [9:0]              sample_code,
   output var  logic [9:0]              sample_code_oe,
   output var  logic                    in_range_flag,
   output var  logic                    in_range_flag_oe
);

   // ----------------------------------------------------------------
   // Quantiser stage: saturate and flag
   // ----------------------------------------------------------------
   logic [ADCOP_CODE_W-1:0] stage_code;
   logic                    stage_flag;
   logic [ADCOP_CODE_W-1:0] next_stage_code;
   logic                    next_stage_flag;

   // Codes outside the converter range saturate and clear the flag
   always_comb
   begin
      if (raw_sample < $signed(ADCOP_RAW_MIN))
      begin
         next_stage_code = ADCOP_CODE_MIN;
         next_stage_flag = ADCOP_FLAG_OUT;
      end
      else if (raw_sample > $signed(ADCOP_RAW_MAX))
      begin
         next_stage_code = ADCOP_CODE_MAX;
         next_stage_flag = ADCOP_FLAG_OUT;
      end
      else
      begin
         next_stage_code = raw_sample[ADCOP_CODE_W-1:0];
         next_stage_flag = ADCOP_FLAG_IN;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         stage_code <= ADCOP_CODE_MIN;
         stage_flag <= ADCOP_FLAG_OUT;
      end
      else
      begin
         stage_code <= next_stage_code;
         stage_flag <= next_stage_flag;
      end
   end

   // ----------------------------------------------------------------
   // Output stage: hold and drive enable
   // ----------------------------------------------------------------
   logic [ADCOP_CODE_W-1:0] next_sample_code;
   logic                    next_in_range_flag;
   logic [ADCOP_CODE_W-1:0] next_sample_code_oe;
   logic                    next_in_range_flag_oe;

   // Enables are worked out apart from hold so drive control always acts
   always_comb
   begin
      next_sample_code   = sample_code;
      next_in_range_flag = in_range_flag;
      if (low_power_hold != ADCOP_HOLD_ON)
      begin
         next_sample_code   = stage_code;
         next_in_range_flag = stage_flag;
      end
      if (output_drive_n == ADCOP_DRIVE_ON)
      begin
         next_in_range_flag_oe = ADCOP_OE_ON;
      end
      else
      begin
         next_in_range_flag_oe = ADCOP_OE_OFF;
      end
      next_sample_code_oe = {ADCOP_CODE_W{next_in_range_flag_oe}};
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sample_code      <= ADCOP_CODE_MIN;
         in_range_flag    <= ADCOP_FLAG_OUT;
         sample_code_oe   <= {ADCOP_CODE_W{ADCOP_OE_OFF}};
         in_range_flag_oe <= ADCOP_OE_OFF;
      end
      else
      begin
         sample_code      <= next_sample_code;
         in_range_flag    <= next_in_range_flag;
         sample_code_oe   <= next_sample_code_oe;
         in_range_flag_oe <= next_in_range_flag_oe;
      end
   end

   // ----------------------------------------------------------------
   // Checks: drive control
   // ----------------------------------------------------------------
   // Enables follow the drive control one edge later, hold or not
   drive_enable_a : assert property (@(posedge ref_clk) disable iff (rst)
      !output_drive_n
      |=> (sample_code_oe == {ADCOP_CODE_W{ADCOP_OE_ON}}) && in_range_flag_oe)
      else $error("outputs not driven with drive control low");

   release_hiz_a : assert property (@(posedge ref_clk) disable iff (rst)
      output_drive_n
      |=> (sample_code_oe == {ADCOP_CODE_W{ADCOP_OE_OFF}}) && !in_range_flag_oe)
      else $error("outputs not released with drive control high");

   hold_drive_a : assert property (@(posedge ref_clk) disable iff (rst)
      (low_power_hold == ADCOP_HOLD_ON) && (output_drive_n == ADCOP_DRIVE_ON)
      |=> in_range_flag_oe && (sample_code_oe == {ADCOP_CODE_W{ADCOP_OE_ON}}))
      else $error("drive control ignored during hold");

   oe_follow_a : assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) && $changed(output_drive_n)
      |=> $changed(in_range_flag_oe))
      else $error("enable did not follow drive control");

   // ----------------------------------------------------------------
   // Checks: hold and run
   // ----------------------------------------------------------------
   // The flag freezes with the code so a held pair stays matched
   hold_freeze_a : assert property (@(posedge ref_clk) disable iff (rst)
      low_power_hold
      |=> $stable(sample_code))
      else $error("code changed during hold");

   hold_flag_a : assert property (@(posedge ref_clk) disable iff (rst)
      low_power_hold
      |=> $stable(in_range_flag))
      else $error("range flag changed during hold");

   run_update_a : assert property (@(posedge ref_clk) disable iff (rst)
      !low_power_hold ##1 !$past(low_power_hold) |-> sample_code == $past(stage_code))
      else $error("code not updated while running");

   run_flag_a : assert property (@(posedge ref_clk) disable iff (rst)
      !low_power_hold
      |=> in_range_flag == $past(stage_flag))
      else $error("range flag not updated while running");

   hold_exit_a : assert property (@(posedge ref_clk) disable iff (rst)
      $fell(low_power_hold)
      |=> (sample_code == $past(stage_code)) && (in_range_flag == $past(stage_flag)))
      else $error("outputs not resumed after hold");

   // ----------------------------------------------------------------
   // Checks: code and range flag
   // ----------------------------------------------------------------
   // A cleared range flag always comes with code 0 or 1023
   in_range_a : assert property (@(posedge ref_clk) disable iff (rst)
      (raw_sample >= $signed(ADCOP_RAW_MIN)) && (raw_sample <= $signed(ADCOP_RAW_MAX))
      ##1 !low_power_hold
      |=> in_range_flag && (sample_code == $past(raw_sample[ADCOP_CODE_W-1:0], 2)))
      else $error("in-range code or flag wrong");

   stage_pass_a : assert property (@(posedge ref_clk) disable iff (rst)
      (raw_sample >= $signed(ADCOP_RAW_MIN)) && (raw_sample <= $signed(ADCOP_RAW_MAX))
      |=> (stage_code == $past(raw_sample[ADCOP_CODE_W-1:0])) && (stage_flag == ADCOP_FLAG_IN))
      else $error("in-range stage result wrong");

   under_sat_a : assert property (@(posedge ref_clk) disable iff (rst)
      (raw_sample < $signed(ADCOP_RAW_MIN)) ##1 !low_power_hold
      |=> sample_code == ADCOP_CODE_MIN && !in_range_flag)
      else $error("underflow not saturated to zero");

   over_sat_a : assert property (@(posedge ref_clk) disable iff (rst)
      (raw_sample > $signed(ADCOP_RAW_MAX)) ##1 !low_power_hold
      |=> sample_code == ADCOP_CODE_MAX && !in_range_flag)
      else $error("overflow not saturated to full scale");

   stage_under_a : assert property (@(posedge ref_clk) disable iff (rst)
      raw_sample < $signed(ADCOP_RAW_MIN)
      |=> (stage_code == ADCOP_CODE_MIN) && (stage_flag == ADCOP_FLAG_OUT))
      else $error("underflow stage result wrong");

   stage_over_a : assert property (@(posedge ref_clk) disable iff (rst)
      raw_sample > $signed(ADCOP_RAW_MAX)
      |=> (stage_code == ADCOP_CODE_MAX) && (stage_flag == ADCOP_FLAG_OUT))
      else $error("overflow stage result wrong");

   flag_pair_a : assert property (@(posedge ref_clk) disable iff (rst)
      in_range_flag == ADCOP_FLAG_OUT
      |-> (sample_code == ADCOP_CODE_MIN) || (sample_code == ADCOP_CODE_MAX))
      else $error("cleared range flag with a mid-scale code");

   stage_flag_pair_a : assert property (@(posedge ref_clk) disable iff (rst)
      stage_flag == ADCOP_FLAG_OUT
      |-> (stage_code == ADCOP_CODE_MIN) || (stage_code == ADCOP_CODE_MAX))
      else $error("cleared stage flag with a mid-scale code");

   // ----------------------------------------------------------------
   // Checks: pipeline
   // ----------------------------------------------------------------
   // A new stage result reaches the pins on the next edge while hold is low
   pipe_latency_a : assert property (@(posedge ref_clk) disable iff (rst)
      $changed(stage_code) && !low_power_hold |=> sample_code == $past(stage_code))
      else $error("pipeline latency not fixed");

   pipe_flag_a : assert property (@(posedge ref_clk) disable iff (rst)
      $changed(stage_flag) && !low_power_hold
      |=> in_range_flag == $past(stage_flag))
      else $error("range flag latency not fixed");

endmodule : adcop_top
`default_nettype wire

// file: testbench/adcop_capture.sv
// Capture logic model: latches the port pins on each rising edge.
// Assumes released pins read back as the inverse of the last level.
`timescale 1ns/1ns
`default_nettype none
module adcop_capture
(
   input  wire logic       ref_clk,
   input  wire logic [9:0] sample_code,
   input  wire logic [9:0] sample_code_oe,
   input  wire logic       in_range_flag,
   input  wire logic       in_range_flag_oe,
   output var  logic [9:0] cap_code,
   output var  logic       cap_flag
);
   // Latches on one consistent edge
   always_ff @(posedge ref_clk)
   begin
      cap_code <= (sample_code & sample_code_oe) | (~cap_code & ~sample_code_oe);
      cap_flag <= in_range_flag_oe ? in_range_flag : ~cap_flag;
   end
endmodule : adcop_capture
`default_nettype wire

// file: testbench/adcop_top_bench.sv
// Bench for the converter output port: code stream, hold, drive control.
// Assumes adcop_top and the capture model adcop_capture.
`timescale 1ns/1ns
`default_nettype none
module adcop_top_bench;
   import adcop_pkg::*;
   logic               ref_clk = 1'b0;
   logic               rst     = 1'b1;
   logic signed [11:0] raw     = 12'sh000;
   logic               drv_n   = 1'b0;
   logic               hold    = 1'b0;
   logic [9:0]         code, oe, cap_code;
   logic               flag, flag_oe, cap_flag;
   int                 n_fail = 0;
   int                 total_checks = 0;
   logic signed [11:0] tv [7] = '{12'sh005, 12'sh000, 12'sh3ff, 12'shfff, 12'sh400,
                                  12'sh200, 12'sh7ff};

   adcop_top u_dut (.ref_clk(ref_clk), .rst(rst), .raw_sample(raw), .output_drive_n(drv_n),
      .low_power_hold(hold), .sample_code(code), .sample_code_oe(oe),
      .in_range_flag(flag), .in_range_flag_oe(flag_oe));
   adcop_capture u_cap (.ref_clk(ref_clk), .sample_code(code), .sample_code_oe(oe),
      .in_range_flag(flag), .in_range_flag_oe(flag_oe), .cap_code(cap_code),
      .cap_flag(cap_flag));

   initial forever #10 ref_clk = ~ref_clk;

   task chk(input logic [9:0] c, input logic f, input logic [9:0] ec, input logic ef);
      total_checks++;
      if (c !== ec || f !== ef)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h %b want %h %b", $time, c, f, ec, ef);
      end
   endtask : chk

   task t_stream;
      logic signed [11:0] v;
      logic [9:0]         ec;
      logic               ef;
      for (int i = 0; i < 10; i++)
      begin
         @(negedge ref_clk);
         if (i < 7) raw = tv[i];
         if (i >= 3)
         begin
            v  = tv[i-3];
            ec = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : v[9:0];
            ef = (v >= 0) && (v <= 1023);
            chk(cap_code, cap_flag, ec, ef);
         end
      end
      $display("stream done");
   endtask : t_stream

   task t_hold;
      @(negedge ref_clk);
      hold = 1'b1;
      raw  = 12'sh055;
      repeat (5) @(negedge ref_clk);
      chk(code, flag, 10'h3ff, 1'b0);
      hold = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(code, flag, 10'h055, 1'b1);
      $display("hold done");
   endtask : t_hold

   task t_drive;
      drv_n = 1'b1;
      @(negedge ref_clk);
      chk(oe, flag_oe, 10'h000, 1'b0);
      drv_n = 1'b0;
      @(negedge ref_clk);
      chk(oe, flag_oe, 10'h3ff, 1'b1);
      $display("drive done");
   endtask : t_drive

   task conclude;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_stream;
      t_hold;
      t_drive;
      conclude;
   end

   initial
   begin
      #10000;
      n_fail++;
      conclude;
   end
endmodule : adcop_top_bench
`default_nettype wire
